// ===== dctcm_pkg.sv
// Shared constants and types of the dual-channel torque cutoff monitor.
package dctcm_pkg;
   // ***********************************************
   // Timing
   // ***********************************************
   localparam int CLK_KHZ = 10000;
   localparam int TEST_PULSE_US = 1000;
   // Longest tolerated off pulse, rounded down to whole cycles.
   localparam int FILT_CYCLES = (TEST_PULSE_US * CLK_KHZ) / 1000;
   localparam int FILT_CW = 16;
   // ***********************************************
   // Register map
   // ***********************************************
   localparam int REG_AW = 8;
   localparam logic [REG_AW-1:0] CTRL_OFS = 8'h00;
   localparam logic [REG_AW-1:0] STATUS_OFS = 8'h04;
   localparam logic [31:0] CTRL_RESET = 32'h00000000;
   localparam int CTRL_SERVO_ON_BIT = 0;
   localparam int CTRL_TORQUE_BIT = 1;
   localparam int CTRL_ALM_CLR_BIT = 2;
   localparam int STAT_OFF_A_BIT = 0;
   localparam int STAT_OFF_B_BIT = 1;
   localparam int STAT_BOTH_BIT = 2;
   localparam int STAT_ALARM_BIT = 3;
   localparam int STAT_DBRAKE_BIT = 4;
   localparam int STAT_DECEL_BIT = 5;
   localparam int STAT_STATE_LSB = 6;
   // ***********************************************
   // Stop sequencing states
   // ***********************************************
   typedef enum logic [1:0]
   {
      ST_RUN = 2'b00,
      ST_DECEL = 2'b01,
      ST_DBRAKE = 2'b10,
      ST_SHUTOFF = 2'b11
   } dctcm_state_t;
endpackage : dctcm_pkg

// ===== dctcm_if.sv
// Interfaces between the cutoff monitor core, its input filters and its bus slave.
`timescale 1ns/10ps
interface dctcm_ch_if;
   logic closed;
   logic shutoff;
   modport filt
   (
      output closed,
      output shutoff
   );
   modport core
   (
      input closed,
      input shutoff
   );
endinterface : dctcm_ch_if

interface dctcm_reg_if;
   logic wr_en;
   logic [dctcm_pkg::REG_AW-1:0] wr_addr;
   logic [31:0] wr_data;
   logic [dctcm_pkg::REG_AW-1:0] rd_addr;
   logic [31:0] rd_data;
   modport bus
   (
      output wr_en,
      output wr_addr,
      output wr_data,
      output rd_addr,
      input rd_data
   );
   modport regs
   (
      input wr_en,
      input wr_addr,
      input wr_data,
      input rd_addr,
      output rd_data
   );
endinterface : dctcm_reg_if

// ===== dctcm_filter.sv
// Safety input synchroniser and test-pulse filter for one channel.
`timescale 1ns/10ps
module dctcm_filter #(
   parameter int LIMIT = dctcm_pkg::FILT_CYCLES
)
(
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic reset_in,
   // Contact level, high while closed against the common
   input wire logic contact_in,
   // Filtered channel state
   dctcm_ch_if.filt ch
);
   localparam int CW = dctcm_pkg::FILT_CW;
   localparam logic [CW-1:0] LIM = LIMIT[CW-1:0];

   if (LIMIT < 1 || LIMIT >= (1 << CW))
   begin : g_bad_limit
      $error("dctcm_filter: LIMIT out of range");
   end

   logic meta;
   logic sync;
   logic [CW-1:0] cnt;
   logic shutoff;

   always_ff @(posedge sys_clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         meta <= 1'b0;
         sync <= 1'b0;
      end
      else
      begin
         meta <= contact_in;
         sync <= meta;
      end
   end

   always_ff @(posedge sys_clk_in or posedge reset_in)
   begin
      if (reset_in)
         cnt <= '0;
      else if (sync)
         cnt <= '0;
      else if (cnt != LIM)
         cnt <= cnt + 1'b1;
   end

   // The channel is cut only once an open outlasts the test-pulse width,
   // so a short test pulse can neither cut nor toggle the monitors.
   // pulse width filter
   always_ff @(posedge sys_clk_in or posedge reset_in)
   begin
      if (reset_in)
         shutoff <= 1'b1;
      else if (sync)
         shutoff <= 1'b0;
      else if (cnt == LIM)
         shutoff <= 1'b1;
   end

   assign ch.closed = sync;
   assign ch.shutoff = shutoff;

   a_close_release: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      sync |=> !shutoff)
      else $error("channel not released while closed");
   a_long_open_cut: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      (!sync && cnt == LIM) |=> shutoff)
      else $error("long open did not cut channel");
   a_no_early_cut: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      $rose(shutoff) |-> ($past(cnt) == LIM && !$past(sync)))
      else $error("channel cut by a short pulse");
endmodule : dctcm_filter

// ===== dctcm_ahb.sv
// Zero-wait-state AHB-Lite slave that feeds the register port.
`timescale 1ns/10ps
module dctcm_ahb
(
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic reset_in,
   // AHB-Lite slave
   input wire logic hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [31:0] hwdata_in,
   input wire logic hready_in,
   output logic [31:0] hrdata_out,
   output logic hreadyout_out,
   output logic hresp_out,
   // Register port
   dctcm_reg_if.bus rp
);
   localparam int AW = dctcm_pkg::REG_AW;

   logic take;
   logic wr_pend;
   logic [AW-1:0] wr_addr;

   // Read data is captured in the address phase so it stands for the data phase.
   assign take = hsel_in && htrans_in[1] && hready_in;

   always_ff @(posedge sys_clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         wr_pend <= 1'b0;
         wr_addr <= '0;
         hrdata_out <= 32'h00000000;
         hreadyout_out <= 1'b1;
         hresp_out <= 1'b0;
      end
      else
      begin
         wr_pend <= take && hwrite_in;
         if (take)
            wr_addr <= haddr_in[AW-1:0];
         if (take && !hwrite_in)
            hrdata_out <= rp.rd_data;
         hreadyout_out <= 1'b1;
         hresp_out <= 1'b0;
      end
   end

   assign rp.wr_en = wr_pend;
   assign rp.wr_addr = wr_addr;
   assign rp.wr_data = hwdata_in;
   assign rp.rd_addr = haddr_in[AW-1:0];
endmodule : dctcm_ahb

// ===== dctcm_top.sv
// Dual-channel torque cutoff core: channel state, monitors, stop sequencing.
`timescale 1ns/10ps

// Operation
// - Channel one is cut while its input is open, released only while closed.
// - Channel two is cut while its input is open, released only while closed.
// - Monitor A closes while channel one is cut, open while released.
// - Monitor B closes while channel two is cut, open while released.
// - The path between both monitors is on only when both inputs are open.
// - Forced-stop deceleration is unavailable in torque control mode.
// - Opening inputs while running stops by dynamic brake and raises the alarm.
module dctcm_top #(
   parameter int FILT_CYCLES = dctcm_pkg::FILT_CYCLES
)
(
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic reset_in,
   // Safety inputs, high while closed against the common
   input wire logic safe_off_in_a_in,
   input wire logic safe_off_in_b_in,
   // Forced stop 2, high while closed, low requests deceleration
   input wire logic forced_stop_2_input_in,
   // Motion state from the drive logic
   input wire logic motor_running_in,
   // AHB-Lite slave
   input wire logic hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic [31:0] hwdata_in,
   input wire logic hready_in,
   output logic [31:0] hrdata_out,
   output logic hreadyout_out,
   output logic hresp_out,
   // Power stage controls
   output logic base_shutoff_a_out,
   output logic base_shutoff_b_out,
   output logic power_enable_out,
   output logic forced_decel_out,
   output logic dynamic_brake_out,
   output logic cutoff_timing_alarm_out,
   // Monitors, high while the contact to monitor_common is closed
   output logic shutoff_monitor_a_out,
   output logic shutoff_monitor_b_out,
   output logic monitor_ab_out
);
   // ***********************************************
   // Register decode
   // ***********************************************
   function automatic logic hit(input logic [dctcm_pkg::REG_AW-1:0] addr,
                                input logic [dctcm_pkg::REG_AW-1:0] ofs);
      hit = (addr == ofs);
   endfunction : hit

   dctcm_ch_if ch_a();
   dctcm_ch_if ch_b();
   dctcm_reg_if rp();

   // ***********************************************
   // Input filters and bus slave
   // ***********************************************
   // channel one filter
   dctcm_filter #(
      .LIMIT(FILT_CYCLES)
   ) u_filt_a (
      .sys_clk_in(sys_clk_in),
      .reset_in(reset_in),
      .contact_in(safe_off_in_a_in),
      .ch(ch_a)
   );

   dctcm_filter #(
      .LIMIT(FILT_CYCLES)
   ) u_filt_b (
      .sys_clk_in(sys_clk_in),
      .reset_in(reset_in),
      .contact_in(safe_off_in_b_in),
      .ch(ch_b)
   );

   // Only whole-word transfers are expected, so the size is not decoded.
   logic unused_size;
   assign unused_size = ^hsize_in;

   dctcm_ahb u_ahb (
      .sys_clk_in(sys_clk_in),
      .reset_in(reset_in),
      .hsel_in(hsel_in),
      .haddr_in(haddr_in),
      .htrans_in(htrans_in),
      .hwrite_in(hwrite_in),
      .hwdata_in(hwdata_in),
      .hready_in(hready_in),
      .hrdata_out(hrdata_out),
      .hreadyout_out(hreadyout_out),
      .hresp_out(hresp_out),
      .rp(rp)
   );

   // ***********************************************
   // Forced stop 2 synchroniser
   // ***********************************************
   logic em2_meta;
   logic em2_sync;

   always_ff @(posedge sys_clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         em2_meta <= 1'b1;
         em2_sync <= 1'b1;
      end
      else
      begin
         em2_meta <= forced_stop_2_input_in;
         em2_sync <= em2_meta;
      end
   end

   // ***********************************************
   // Control register
   // ***********************************************
   logic servo_on;
   logic torque_mode;
   logic alm_clr;
   logic ctrl_wr;

   assign ctrl_wr = rp.wr_en && hit(rp.wr_addr, dctcm_pkg::CTRL_OFS);
   assign alm_clr = ctrl_wr && rp.wr_data[dctcm_pkg::CTRL_ALM_CLR_BIT];

   always_ff @(posedge sys_clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         servo_on <= dctcm_pkg::CTRL_RESET[dctcm_pkg::CTRL_SERVO_ON_BIT];
         torque_mode <= dctcm_pkg::CTRL_RESET[dctcm_pkg::CTRL_TORQUE_BIT];
      end
      else if (ctrl_wr)
      begin
         servo_on <= rp.wr_data[dctcm_pkg::CTRL_SERVO_ON_BIT];
         torque_mode <= rp.wr_data[dctcm_pkg::CTRL_TORQUE_BIT];
      end
   end

   // ***********************************************
   // Stop sequencing
   // ***********************************************
   dctcm_pkg::dctcm_state_t state;
   dctcm_pkg::dctcm_state_t next_state;
   logic any_off;

   assign any_off = ch_a.shutoff || ch_b.shutoff;

   always_comb
   begin
      next_state = state;
      case (state)
         dctcm_pkg::ST_RUN:
         begin
            if (any_off && motor_running_in)
               next_state = dctcm_pkg::ST_DBRAKE;
            else if (any_off)
               next_state = dctcm_pkg::ST_SHUTOFF;
            else if (!em2_sync && !torque_mode && motor_running_in)
               next_state = dctcm_pkg::ST_DECEL;
         end
         dctcm_pkg::ST_DECEL:
         begin
            if (any_off && motor_running_in)
               next_state = dctcm_pkg::ST_DBRAKE;
            else if (any_off)
               next_state = dctcm_pkg::ST_SHUTOFF;
            else if (em2_sync || torque_mode)
               next_state = dctcm_pkg::ST_RUN;
         end
         dctcm_pkg::ST_DBRAKE:
         begin
            if (!motor_running_in)
               next_state = dctcm_pkg::ST_SHUTOFF;
         end
         dctcm_pkg::ST_SHUTOFF:
         begin
            if (!any_off)
               next_state = dctcm_pkg::ST_RUN;
         end
         default:
         begin
            next_state = dctcm_pkg::ST_SHUTOFF;
         end
      endcase
   end

   always_ff @(posedge sys_clk_in or posedge reset_in)
   begin
      if (reset_in)
         state <= dctcm_pkg::ST_SHUTOFF;
      else
         state <= next_state;
   end

   // The alarm is sticky until software clears it; a new cut in the
   // clearing cycle wins so that no timing fault goes unreported.
   // timing alarm
   always_ff @(posedge sys_clk_in or posedge reset_in)
   begin
      if (reset_in)
         cutoff_timing_alarm_out <= 1'b0;
      else if (next_state == dctcm_pkg::ST_DBRAKE && state != dctcm_pkg::ST_DBRAKE)
         cutoff_timing_alarm_out <= 1'b1;
      else if (alm_clr)
         cutoff_timing_alarm_out <= 1'b0;
   end

   // ***********************************************
   // Power stage and monitors
   // ***********************************************
   always_ff @(posedge sys_clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         base_shutoff_a_out <= 1'b1;
         base_shutoff_b_out <= 1'b1;
         power_enable_out <= 1'b0;
         forced_decel_out <= 1'b0;
         dynamic_brake_out <= 1'b0;
      end
      else
      begin
         base_shutoff_a_out <= ch_a.shutoff;
         base_shutoff_b_out <= ch_b.shutoff;
         power_enable_out <= servo_on && !any_off && next_state != dctcm_pkg::ST_DBRAKE;
         forced_decel_out <= (next_state == dctcm_pkg::ST_DECEL);
         dynamic_brake_out <= (next_state == dctcm_pkg::ST_DBRAKE);
      end
   end

   // Each channel is reported on its own contact; the path between the two
   // contacts only conducts when both are closed.
   always_ff @(posedge sys_clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         shutoff_monitor_a_out <= 1'b1;
         shutoff_monitor_b_out <= 1'b1;
         monitor_ab_out <= 1'b1;
      end
      else
      begin
         shutoff_monitor_a_out <= ch_a.shutoff;
         shutoff_monitor_b_out <= ch_b.shutoff;
         monitor_ab_out <= ch_a.shutoff && ch_b.shutoff;
      end
   end

   // ***********************************************
   // Status read
   // ***********************************************
   always_comb
   begin
      rp.rd_data = 32'h00000000;
      if (hit(rp.rd_addr, dctcm_pkg::CTRL_OFS))
      begin
         rp.rd_data[dctcm_pkg::CTRL_SERVO_ON_BIT] = servo_on;
         rp.rd_data[dctcm_pkg::CTRL_TORQUE_BIT] = torque_mode;
      end
      else if (hit(rp.rd_addr, dctcm_pkg::STATUS_OFS))
      begin
         rp.rd_data[dctcm_pkg::STAT_OFF_A_BIT] = ch_a.shutoff;
         rp.rd_data[dctcm_pkg::STAT_OFF_B_BIT] = ch_b.shutoff;
         rp.rd_data[dctcm_pkg::STAT_BOTH_BIT] = monitor_ab_out;
         rp.rd_data[dctcm_pkg::STAT_ALARM_BIT] = cutoff_timing_alarm_out;
         rp.rd_data[dctcm_pkg::STAT_DBRAKE_BIT] = dynamic_brake_out;
         rp.rd_data[dctcm_pkg::STAT_DECEL_BIT] = forced_decel_out;
         rp.rd_data[dctcm_pkg::STAT_STATE_LSB +: 2] = state;
      end
   end

   // ***********************************************
   // Assertions
   // ***********************************************
   a_mon_a_cut: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      ch_a.shutoff |=> (shutoff_monitor_a_out && base_shutoff_a_out))
      else $error("monitor A open while channel one cut");
   a_mon_a_free: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      ch_a.closed ##1 ch_a.closed |=> !shutoff_monitor_a_out)
      else $error("monitor A closed while channel one released");
   a_mon_b_cut: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      ch_b.shutoff |=> (shutoff_monitor_b_out && base_shutoff_b_out))
      else $error("monitor B open while channel two cut");
   a_mon_b_free: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      ch_b.closed ##1 ch_b.closed |=> !shutoff_monitor_b_out)
      else $error("monitor B closed while channel two released");
   a_mon_both_path: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      monitor_ab_out == ($past(ch_a.shutoff) && $past(ch_b.shutoff)))
      else $error("combined path disagrees with channel monitors");
   a_no_decel_torque: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      $rose(forced_decel_out) |-> !$past(torque_mode))
      else $error("forced decel started in torque mode");
   a_alarm_on_run: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      (any_off && motor_running_in && !alm_clr &&
       (state == dctcm_pkg::ST_RUN || state == dctcm_pkg::ST_DECEL))
      |=> (dynamic_brake_out && cutoff_timing_alarm_out && !power_enable_out))
      else $error("cut while running without brake and alarm");
   a_brake_hold: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      (dynamic_brake_out && motor_running_in) |=> dynamic_brake_out)
      else $error("dynamic brake dropped while motor running");

   c_both_cut: cover property (@(posedge sys_clk_in) disable iff (reset_in)
      $rose(monitor_ab_out));
   c_alarm: cover property (@(posedge sys_clk_in) disable iff (reset_in)
      $rose(cutoff_timing_alarm_out));
   c_decel: cover property (@(posedge sys_clk_in) disable iff (reset_in)
      $rose(forced_decel_out) ##[1:50] !motor_running_in);
   c_power_up: cover property (@(posedge sys_clk_in) disable iff (reset_in)
      $rose(power_enable_out));
endmodule : dctcm_top

// ===== dctcm_relay_model.sv
// Behavioural safety relay driving both safety contacts and forced stop 2.
`timescale 1ns/10ps
module dctcm_relay_model #(
   parameter int LIMIT = 20
)
(
   // Clock and motion state
   input wire logic sys_clk_in,
   input wire logic motor_running_in,
   // Contacts, high while closed
   output logic contact_a_out,
   output logic contact_b_out,
   output logic forced_stop_2_out
);
   initial
   begin
      contact_a_out = 1'b0;
      contact_b_out = 1'b0;
      forced_stop_2_out = 1'b1;
   end
   // stop before cutoff, both at once
   task set_contacts(input logic a, input logic b, input logic force_open);
      @(posedge sys_clk_in);
      if (force_open || !motor_running_in || (a && b))
      begin
         contact_a_out <= a;
         contact_b_out <= b;
      end
   endtask : set_contacts
   // off time clipped to the permitted width
   task pulse(input int ch, input int width);
      int w;
      w = (width > LIMIT) ? LIMIT : width;
      @(posedge sys_clk_in);
      if (ch == 0) contact_a_out <= 1'b0;
      else contact_b_out <= 1'b0;
      repeat (w) @(posedge sys_clk_in);
      contact_a_out <= 1'b1;
      contact_b_out <= 1'b1;
   endtask : pulse
   task set_em2(input logic v);
      @(posedge sys_clk_in);
      forced_stop_2_out <= v;
   endtask : set_em2
endmodule : dctcm_relay_model

// ===== dual_channel_torque_cutoff_monitor_tb_top.sv
// Self-checking testbench of the dual-channel torque cutoff monitor.
`timescale 1ns/10ps
module dual_channel_torque_cutoff_monitor_tb_top;
   localparam int FILT_C = 20;
   localparam logic [31:0] CTRL = 32'h00000000;
   localparam logic [31:0] STAT = 32'h00000004;
   logic sys_clk_in, reset_in, motor_running_in, hsel_in, hwrite_in, hready_in;
   logic [31:0] haddr_in, hwdata_in, hrdata_out, rd;
   logic [1:0] htrans_in;
   logic [2:0] hsize_in;
   logic hreadyout_out, hresp_out, bsa, bsb, pwr, dec, dbk, alm, mon_a, mon_b, mon_ab;
   logic con_a, con_b, em2;
   logic [3:0] obs;
   int n_errors = 0;
   int comparisons = 0;
   int seed = 32'hF77E;
   int exp_a, exp_b, w, ch, seen;
   assign hready_in = hreadyout_out;
   assign obs = {alm, dbk, dec, pwr};
   initial
   begin
      sys_clk_in = 1'b0;
      forever #50 sys_clk_in = ~sys_clk_in;
   end
   dctcm_top #(.FILT_CYCLES(FILT_C)) dut (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
      .safe_off_in_a_in(con_a), .safe_off_in_b_in(con_b), .forced_stop_2_input_in(em2),
      .motor_running_in(motor_running_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
      .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(hsize_in),
      .hwdata_in(hwdata_in), .hready_in(hready_in), .hrdata_out(hrdata_out),
      .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .base_shutoff_a_out(bsa),
      .base_shutoff_b_out(bsb), .power_enable_out(pwr), .forced_decel_out(dec),
      .dynamic_brake_out(dbk), .cutoff_timing_alarm_out(alm),
      .shutoff_monitor_a_out(mon_a), .shutoff_monitor_b_out(mon_b), .monitor_ab_out(mon_ab));
   dctcm_relay_model #(.LIMIT(FILT_C)) relay (.sys_clk_in(sys_clk_in),
      .motor_running_in(motor_running_in), .contact_a_out(con_a), .contact_b_out(con_b),
      .forced_stop_2_out(em2));
   // ****************************************
   // Checking and bus tasks
   // ****************************************
   task close_out;
      $display("comparisons %0d n_errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : close_out
   task chk(input string nm, input logic [31:0] sv, input logic [31:0] ev);
      comparisons++;
      if (sv !== ev)
      begin
         n_errors++;
         $display("FAIL %s expected %h seen %h", nm, ev, sv);
      end
   endtask : chk
   task hwait;
      int n;
      n = 0;
      do
      begin
         @(posedge sys_clk_in);
         n++;
      end
      while (hready_in !== 1'b1 && n < 50);
      if (hready_in !== 1'b1)
      begin
         chk("hready", 1'b0, 1'b1);
         close_out();
      end
   endtask : hwait
   // Address phase held until hready, then the data phase until hready again.
   task xfer(input logic [31:0] a, input logic wr, input logic [31:0] wd);
      hsel_in <= 1'b1;
      haddr_in <= a;
      htrans_in <= 2'h2;
      hwrite_in <= wr;
      hwait();
      hsel_in <= 1'b0;
      htrans_in <= 2'h0;
      hwdata_in <= wd;
      hwait();
      rd = hrdata_out;
      chk("hready_hresp", {hreadyout_out, hresp_out}, 2'h2);
   endtask : xfer
   // Waits for the model's channel state, then compares every monitor.
   task settle;
      int n;
      n = 0;
      while ((bsa !== exp_a[0] || bsb !== exp_b[0]) && n < FILT_C + 20)
      begin
         @(posedge sys_clk_in);
         n++;
      end
      // A channel that never reaches its expected state ends the run here.
      if (bsa !== exp_a[0] || bsb !== exp_b[0])
      begin
         chk("settle_timeout", 1'b0, 1'b1);
         close_out();
      end
      @(posedge sys_clk_in);
      chk("base_shutoff_a", bsa, exp_a);
      chk("base_shutoff_b", bsb, exp_b);
      chk("monitor_a", mon_a, exp_a);
      chk("monitor_b", mon_b, exp_b);
      chk("monitor_ab", mon_ab, exp_a & exp_b);
   endtask : settle
   task wait_obs(input int i, input logic v);
      int n;
      n = 0;
      while (obs[i] !== v && n < FILT_C + 20)
      begin
         @(posedge sys_clk_in);
         n++;
      end
      chk("obs", obs[i], v);
      if (obs[i] !== v)
         close_out();
   endtask : wait_obs
   task set_ch(input logic a, input logic b, input logic f);
      exp_a = !a;
      exp_b = !b;
      relay.set_contacts(a, b, f);
      settle();
   endtask : set_ch
   // ****************************************
   // Main sequence
   // ****************************************
   initial
   begin
      reset_in = 1'b1;
      motor_running_in = 1'b0;
      hsel_in = 1'b0;
      haddr_in = 32'h00000000;
      htrans_in = 2'h0;
      hwrite_in = 1'b0;
      hsize_in = 3'h2;
      hwdata_in = 32'h00000000;
      repeat (16) @(posedge sys_clk_in);
      chk("reset_cut", {bsa, mon_ab, pwr}, 3'h6);
      reset_in <= 1'b0;
      xfer(CTRL, 1'b0, 32'h00000000);
      chk("ctrl_reset", rd, 32'h00000000);
      for (int i = 0; i < 4; i++)
      begin
         set_ch(i[1], i[0], 1'b1);
         xfer(STAT, 1'b0, 32'h00000000);
         chk("status_cut", rd[2:0], {exp_a[0] & exp_b[0], exp_b[0], exp_a[0]});
         chk("status_state", rd[7:4], (exp_a[0] | exp_b[0]) ? 4'hC : 4'h0);
      end
      for (int k = 0; k < 4; k++)
      begin
         ch = $unsigned($random(seed)) % 2;
         w = (k == 0) ? FILT_C : 1 + $unsigned($random(seed)) % FILT_C;
         seen = 0;
         fork
            relay.pulse(ch, w);
            repeat (w + 8)
            begin
               @(posedge sys_clk_in);
               if (mon_a !== 1'b0 || mon_b !== 1'b0 || bsa !== 1'b0) seen = 1;
            end
         join
         chk("pulse_ignored", seen, 0);
      end
      xfer(32'h00000010, 1'b1, $random(seed));
      xfer(32'h00000010, 1'b0, 32'h00000000);
      chk("unmapped", rd, 32'h00000000);
      xfer(CTRL, 1'b1, 32'h00000003);
      motor_running_in <= 1'b1;
      relay.set_em2(1'b0);
      repeat (FILT_C) @(posedge sys_clk_in);
      chk("decel_torque", dec, 1'b0);
      xfer(CTRL, 1'b1, 32'h00000001);
      wait_obs(1, 1'b1);
      motor_running_in <= 1'b0;
      set_ch(1'b0, 1'b0, 1'b0);
      chk("alarm_after_stop", {alm, dbk}, 2'h0);
      relay.set_em2(1'b1);
      set_ch(1'b1, 1'b1, 1'b0);
      wait_obs(0, 1'b1);
      motor_running_in <= 1'b1;
      set_ch(1'b0, 1'b0, 1'b1);
      wait_obs(2, 1'b1);
      wait_obs(3, 1'b1);
      chk("power_cut", pwr, 1'b0);
      motor_running_in <= 1'b0;
      wait_obs(2, 1'b0);
      set_ch(1'b1, 1'b1, 1'b1);
      xfer(STAT, 1'b0, 32'h00000000);
      chk("alarm_sticky", rd[3], 1'b1);
      xfer(CTRL, 1'b1, 32'h00000005);
      xfer(STAT, 1'b0, 32'h00000000);
      chk("alarm_clear", rd[3], 1'b0);
      chk("status_idle", rd[7:0], 8'h00);
      close_out();
   end
endmodule : dual_channel_torque_cutoff_monitor_tb_top
